// >>> common/tpf_pkg.sv
/*
 * Constants for the timer prescaler, external count front end and the
 * compare/overflow flag block.
 * Assumes one 100 MHz system clock and a plain strobe-style register port.
 */
// Functional notes
// - Compare flags set cycle after match
// - Forced compare strobe never sets flags
// - Compare flags clear on vector or write-one
// - Overflow flag set in normal, clear-on-match
// - Overflow flag clears on vector or write-one
// - Shared prescaler taps 1,8,64,256,1024
// - Prescaler runs free of clock selection
// - Count pin sampled every system cycle
// - Rising-edge registers, latch transparent clock high
// - One tick per selected rising or falling edge
// - Pin edge to counter 2.5-3.5 cycles
// - External ticks never pass through prescaler
// - Hold mode keeps prescaler clear bit value
// - Clearing hold mode clears prescaler clear bit
// - Prescaler clear bit self-clears unless hold
// - Count pin counts even when configured output
package tpf_pkg;
    localparam logic [3:0] TPF_ADDR_GTC   = 4'h0;
    localparam logic [3:0] TPF_ADDR_FLAGS = 4'h1;
    localparam logic [3:0] TPF_ADDR_CTRL  = 4'h2;
    localparam logic [3:0] TPF_ADDR_CNTL  = 4'h3;
    localparam logic [3:0] TPF_ADDR_CNTH  = 4'h4;
    localparam logic [3:0] TPF_ADDR_CMPAL = 4'h5;
    localparam logic [3:0] TPF_ADDR_CMPAH = 4'h6;
    localparam logic [3:0] TPF_ADDR_CMPBL = 4'h7;
    localparam logic [3:0] TPF_ADDR_CMPBH = 4'h8;
    localparam logic [3:0] TPF_ADDR_FORCE = 4'h9;
    localparam int TPF_BIT_SYNC_HOLD = 7;
    localparam int TPF_BIT_PSC_CLEAR = 0;
    localparam int TPF_BIT_OVF  = 0;
    localparam int TPF_BIT_CMPA = 1;
    localparam int TPF_BIT_CMPB = 2;
    localparam int TPF_BIT_FORCE_A = 1;
    localparam int TPF_BIT_FORCE_B = 0;
    localparam logic [7:0] TPF_GTC_RESET   = 8'h00;
    localparam logic [7:0] TPF_FLAGS_RESET = 8'h00;
    localparam logic [7:0] TPF_CTRL_RESET  = 8'h00;
    localparam int TPF_PSC_WIDTH = 10;
    // Control register: [2:0] clock select, [4:3] waveform mode
    localparam int TPF_CS_LSB  = 0;
    localparam int TPF_WGM_LSB = 3;
    typedef enum logic [2:0] {
        TPF_CS_STOP    = 3'b000,
        TPF_CS_DIV1    = 3'b001,
        TPF_CS_DIV8    = 3'b010,
        TPF_CS_DIV64   = 3'b011,
        TPF_CS_DIV256  = 3'b100,
        TPF_CS_DIV1024 = 3'b101,
        TPF_CS_EXT_FALL = 3'b110,
        TPF_CS_EXT_RISE = 3'b111
    } tpf_cs_t;
    typedef enum logic [1:0] {
        TPF_WGM_NORMAL    = 2'b00,
        TPF_WGM_CLR_MATCH = 2'b01,
        TPF_WGM_OTHER_A   = 2'b10,
        TPF_WGM_OTHER_B   = 2'b11
    } tpf_wgm_t;
endpackage

// >>> rtl/tpf_timer.sv
/*
 * Shared prescaler, external count pin front end, 16-bit counter with
 * two compare channels and the overflow / compare match flags.
 * Assumes ext_count_pin is sampled by the block itself; vector-taken
 * strobes come from the interrupt controller as one-cycle pulses.
 */
// Decided for this implementation: the address map and the address-and-strobe port.
module tpf_timer
    import tpf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        ext_count_pin,
    input  wire logic        ovf_vector_taken,
    input  wire logic        cmpa_vector_taken,
    input  wire logic        cmpb_vector_taken,
    output logic             overflow_flag,
    output logic             compare_a_match_flag,
    output logic             compare_b_match_flag,
    output logic             ext_count_tick,
    output logic             prescaler_held
);
    logic                     sync_hold_mode;
    logic                     prescaler_clear;
    logic [TPF_PSC_WIDTH-1:0] psc;
    logic [7:0]               ctrl;
    logic [15:0]              counter_value;
    logic [15:0]              compare_a_value;
    logic [15:0]              compare_b_value;
    logic [7:0]               tmp_high;
    logic                     pin_latch;
    logic                     pin_sync;
    logic                     pin_prev;
    logic                     match_a_d;
    logic                     match_b_d;
    logic                     ovf_d;
    logic                     count_en;
    logic                     rise;
    logic                     fall;
    logic                     cnt_written;
    tpf_cs_t                  clock_select;
    tpf_wgm_t                 waveform_mode_select;

    function automatic logic wr_at(input logic [3:0] a);
        return wr && (addr == a);
    endfunction

    assign clock_select = tpf_cs_t'(ctrl[TPF_CS_LSB +: 3]);
    assign waveform_mode_select = tpf_wgm_t'(ctrl[TPF_WGM_LSB +: 2]);
    assign prescaler_held = prescaler_clear;

    // Sync hold and prescaler clear bits
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_hold_mode  <= TPF_GTC_RESET[TPF_BIT_SYNC_HOLD];
            prescaler_clear <= TPF_GTC_RESET[TPF_BIT_PSC_CLEAR];
        end else if (wr_at(TPF_ADDR_GTC)) begin
            sync_hold_mode  <= wdata[TPF_BIT_SYNC_HOLD];
            // Write of zero to hold mode clears the bit
            prescaler_clear <= wdata[TPF_BIT_SYNC_HOLD] &
                               wdata[TPF_BIT_PSC_CLEAR];
        end else if (!sync_hold_mode) begin
            prescaler_clear <= 1'b0;
        end
    end

    // Free-running prescaler, reset only by the clear bit
    always_ff @(posedge clk) begin
        if (!nrst)
            psc <= '0;
        else if (prescaler_clear || wr_at(TPF_ADDR_GTC) &&
                 wdata[TPF_BIT_PSC_CLEAR])
            psc <= '0;
        else
            psc <= psc + 1'b1;
    end

    // Pin synchroniser: latch stage then register
    // Latch transparent while clk high is modelled as a half-cycle
    // negative-edge stage, giving the 2.5 to 3.5 cycle latency.
    always_ff @(negedge clk) begin
        pin_latch <= ext_count_pin;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_sync <= pin_latch;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // Edge detector tick, registered
    always_ff @(posedge clk) begin
        if (!nrst)
            ext_count_tick <= 1'b0;
        else
            ext_count_tick <= (clock_select == TPF_CS_EXT_RISE) ? rise :
                              (clock_select == TPF_CS_EXT_FALL) ? fall :
                              1'b0;
    end

    // Prescaler taps as enables; external ticks bypass them
    always_comb begin
        unique case (clock_select)
            TPF_CS_STOP:     count_en = 1'b0;
            TPF_CS_DIV1:     count_en = 1'b1;
            TPF_CS_DIV8:     count_en = (psc[2:0] == 3'h7);
            TPF_CS_DIV64:    count_en = (psc[5:0] == 6'h3F);
            TPF_CS_DIV256:   count_en = (psc[7:0] == 8'hFF);
            TPF_CS_DIV1024:  count_en = (psc == 10'h3FF);
            TPF_CS_EXT_FALL,
            TPF_CS_EXT_RISE: count_en = ext_count_tick;
        endcase
        if (prescaler_clear)
            count_en = 1'b0;
    end

    // Control and compare registers, 16-bit via a high-byte holding reg
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl            <= TPF_CTRL_RESET;
            compare_a_value <= 16'hFFFF;
            compare_b_value <= 16'hFFFF;
            tmp_high        <= 8'h00;
        end else if (wr) begin
            unique case (addr)
                TPF_ADDR_CTRL:  ctrl <= wdata;
                TPF_ADDR_CNTH, TPF_ADDR_CMPAH, TPF_ADDR_CMPBH:
                    tmp_high <= wdata;
                TPF_ADDR_CMPAL: compare_a_value <= {tmp_high, wdata};
                TPF_ADDR_CMPBL: compare_b_value <= {tmp_high, wdata};
                default: ;
            endcase
        end
    end

    assign cnt_written = wr_at(TPF_ADDR_CNTL);

    // Counter; clear-on-match wraps at compare A
    always_ff @(posedge clk) begin
        if (!nrst)
            counter_value <= 16'h0000;
        else if (cnt_written)
            counter_value <= {tmp_high, wdata};
        else if (count_en) begin
            if (waveform_mode_select == TPF_WGM_CLR_MATCH &&
                counter_value == compare_a_value)
                counter_value <= 16'h0000;
            else
                counter_value <= counter_value + 16'h0001;
        end
    end

    // Match and overflow events, flagged one timer clock later
    always_ff @(posedge clk) begin
        if (!nrst) begin
            match_a_d <= 1'b0;
            match_b_d <= 1'b0;
            ovf_d     <= 1'b0;
        end else if (count_en) begin
            match_a_d <= (counter_value == compare_a_value) && !cnt_written;
            match_b_d <= (counter_value == compare_b_value) && !cnt_written;
            // Other waveform modes never raise the overflow event
            ovf_d <= (counter_value == 16'hFFFF) &&
                     (waveform_mode_select == TPF_WGM_NORMAL ||
                      waveform_mode_select == TPF_WGM_CLR_MATCH);
        end else begin
            match_a_d <= 1'b0;
            match_b_d <= 1'b0;
            ovf_d     <= 1'b0;
        end
    end

    // Flags: set wins over clear; force strobes have no path here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            overflow_flag        <= TPF_FLAGS_RESET[TPF_BIT_OVF];
            compare_a_match_flag <= TPF_FLAGS_RESET[TPF_BIT_CMPA];
            compare_b_match_flag <= TPF_FLAGS_RESET[TPF_BIT_CMPB];
        end else begin
            if (match_a_d)
                compare_a_match_flag <= 1'b1;
            else if (cmpa_vector_taken ||
                     wr_at(TPF_ADDR_FLAGS) && wdata[TPF_BIT_CMPA])
                compare_a_match_flag <= 1'b0;
            if (match_b_d)
                compare_b_match_flag <= 1'b1;
            else if (cmpb_vector_taken ||
                     wr_at(TPF_ADDR_FLAGS) && wdata[TPF_BIT_CMPB])
                compare_b_match_flag <= 1'b0;
            if (ovf_d)
                overflow_flag <= 1'b1;
            else if (ovf_vector_taken ||
                     wr_at(TPF_ADDR_FLAGS) && wdata[TPF_BIT_OVF])
                overflow_flag <= 1'b0;
        end
    end

    // Read port, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!nrst)
            rdata <= 8'h00;
        else if (rd) begin
            unique case (addr)
                TPF_ADDR_GTC:   rdata <= {sync_hold_mode, 6'h00,
                                          prescaler_clear};
                TPF_ADDR_FLAGS: rdata <= {5'h00, compare_b_match_flag,
                                          compare_a_match_flag,
                                          overflow_flag};
                TPF_ADDR_CTRL:  rdata <= ctrl;
                TPF_ADDR_CNTL:  rdata <= counter_value[7:0];
                TPF_ADDR_CNTH:  rdata <= counter_value[15:8];
                TPF_ADDR_CMPAL: rdata <= compare_a_value[7:0];
                TPF_ADDR_CMPAH: rdata <= compare_a_value[15:8];
                TPF_ADDR_CMPBL: rdata <= compare_b_value[7:0];
                TPF_ADDR_CMPBH: rdata <= compare_b_value[15:8];
                default:        rdata <= 8'h00;
            endcase
        end else
            rdata <= 8'h00;
    end
endmodule // tpf_timer

// >>> verification/tb_tpf_timer.sv
/* Self-checking bench for tpf_timer with a count pin source model.
   Assumes the checker and source model are compiled before it. */
module tb_tpf_timer import tpf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, nrst, wr, rd, pin, run, ovt, cat, cbt;
    logic       ovf, fa, fb, tick, held, want;
    logic       pin_q = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, half, v;
    logic [2:0] mask;
    int         n_fail, n_compared, n_edge, n_tick;
    int         seed = 32'h4C03;
    int         dv[5] = '{1, 8, 64, 256, 1024};
    tpf_timer i_tpf_timer (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_count_pin(pin), .ovf_vector_taken(ovt),
        .cmpa_vector_taken(cat), .cmpb_vector_taken(cbt),
        .overflow_flag(ovf), .compare_a_match_flag(fa),
        .compare_b_match_flag(fb), .ext_count_tick(tick),
        .prescaler_held(held));
    tpf_ext_src i_tpf_ext_src (.clk(clk), .run(run), .half(half), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pin !== pin_q && pin === want) n_edge++;
        if (tick === 1'b1) n_tick++;
        pin_q = pin;
    end
    task automatic chk(string w, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic put(logic [3:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd8(logic [3:0] a, output logic [7:0] q);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) q = rdata;
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial begin
        {nrst, wr, rd, ovt, cat, cbt, run} = 7'h00;
        {addr, wdata, half, want} = 21'h00000;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd8(TPF_ADDR_FLAGS, v);
        chk("flags reset", {8'h00, TPF_FLAGS_RESET}, {8'h00, v});
        rd8(4'hF, v);
        chk("unmapped", 16'h0000, {8'h00, v});
        put(TPF_ADDR_GTC, 8'h7F);
        rd8(TPF_ADDR_GTC, v);
        chk("gtc", 16'h0000, {7'h00, held, v});
        $display("test registers done");
        put(TPF_ADDR_CNTH, 8'hFF);
        put(TPF_ADDR_CNTL, 8'hFC);
        put(TPF_ADDR_CMPAH, 8'hFF);
        put(TPF_ADDR_CMPAL, 8'hFE);
        put(TPF_ADDR_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        put(TPF_ADDR_CTRL, 8'h00);
        rd8(TPF_ADDR_FLAGS, v);
        chk("flags", 16'h0007, {8'h00, v});
        mask = 3'($random(seed)) & 3'b011;
        put(TPF_ADDR_FLAGS, {5'h00, mask});
        chk("w1c", {13'h0, ~mask}, {13'h0, fb, fa, ovf});
        {ovt, cat, cbt} <= 3'b111;
        @(posedge clk) {ovt, cat, cbt} <= 3'b000;
        @(posedge clk);
        chk("vector", 16'h0000, {13'h0, fb, fa, ovf});
        put(TPF_ADDR_FORCE, 8'h03);
        chk("force", 16'h0000, {13'h0, fb, fa, ovf});
        $display("test flags done");
        for (int i = 0; i < 5; i++) begin
            put(TPF_ADDR_GTC, 8'h81);
            put(TPF_ADDR_CNTH, 8'h00);
            put(TPF_ADDR_CNTL, 8'h00);
            put(TPF_ADDR_CTRL, 8'(i + 1));
            repeat (20) @(posedge clk);
            rd8(TPF_ADDR_CNTL, v);
            chk("held count", 16'h0000, {7'h00, ~held, v});
            put(TPF_ADDR_GTC, 8'h00);
            repeat (4 * dv[i]) @(posedge clk);
            put(TPF_ADDR_CTRL, 8'h00);
            rd8(TPF_ADDR_CNTL, v);
            chk("tap", 16'h0001, {15'h0, v >= 4 && v <= 6});
        end
        $display("test prescaler done");
        for (int m = 6; m < 8; m++) begin
            half = 8'(2 + $unsigned($random(seed)) % 3);
            put(TPF_ADDR_CNTH, 8'h00);
            put(TPF_ADDR_CNTL, 8'h00);
            put(TPF_ADDR_CTRL, 8'(m));
            want = m[0];
            n_edge = 0;
            n_tick = 0;
            run <= 1'b1;
            repeat (60) @(posedge clk);
            run <= 1'b0;
            repeat (8) @(posedge clk);
            put(TPF_ADDR_CTRL, 8'h00);
            rd8(TPF_ADDR_CNTL, v);
            chk("ext count", 16'(n_edge), {8'h00, v});
            chk("ext ticks", 16'(n_edge), 16'(n_tick));
        end
        $display("test count pin done");
        complete_run();
    end
endmodule // tb_tpf_timer
bind tpf_timer tpf_sva i_tpf_sva (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_count_pin(ext_count_pin), .ovf_vector_taken(ovf_vector_taken),
    .cmpa_vector_taken(cmpa_vector_taken),
    .cmpb_vector_taken(cmpb_vector_taken), .overflow_flag(overflow_flag),
    .compare_a_match_flag(compare_a_match_flag),
    .compare_b_match_flag(compare_b_match_flag),
    .ext_count_tick(ext_count_tick), .prescaler_held(prescaler_held));

// >>> verification/tpf_ext_src.sv
/* Model of the external clock source on the count pin.
   Assumes run is changed only while the bench wants the pin to move. */
module tpf_ext_src (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial pin = 1'b0;
    // Pin moves just after an edge; stands still outside a burst
    always @(posedge clk) begin
        if (run) begin
            cnt = cnt + 1;
            if (cnt >= half) begin
                cnt = 0;
                pin <= #1 ~pin;
            end
        end
    end
endmodule // tpf_ext_src

// >>> verification/tpf_sva.sv
/* Port checker for tpf_timer: flag clearing, prescaler hold, count pin.
   Assumes a bind to the top module, one clock and sync active-low reset. */
module tpf_sva
    import tpf_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       ext_count_pin,
    input wire logic       ovf_vector_taken,
    input wire logic       cmpa_vector_taken,
    input wire logic       cmpb_vector_taken,
    input wire logic       overflow_flag,
    input wire logic       compare_a_match_flag,
    input wire logic       compare_b_match_flag,
    input wire logic       ext_count_tick,
    input wire logic       prescaler_held
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [2:0] sel;
    wire        gwr = wr && addr == TPF_ADDR_GTC;
    wire        fwr = wr && addr == TPF_ADDR_FLAGS;
    // Shadow of the clock select, so tick polarity can be judged
    always_ff @(posedge clk) begin
        if (!nrst) sel <= 3'h0;
        else if (wr && addr == TPF_ADDR_CTRL) sel <= wdata[2:0];
    end
    cmpa_clear_a:
        assert property ($fell(compare_a_match_flag) |->
            $past(cmpa_vector_taken) || $past(fwr) && $past(wdata[1]))
        else $error("compare A flag fell with no clear");
    cmpb_clear_a:
        assert property ($fell(compare_b_match_flag) |->
            $past(cmpb_vector_taken) || $past(fwr) && $past(wdata[2]))
        else $error("compare B flag fell with no clear");
    ovf_clear_a:
        assert property ($fell(overflow_flag) |->
            $past(ovf_vector_taken) || $past(fwr) && $past(wdata[0]))
        else $error("overflow flag fell with no clear");
    hold_keep_a:
        assert property (prescaler_held && !gwr |=> prescaler_held)
        else $error("prescaler clear bit lost while held");
    hold_drop_a:
        assert property (gwr && !wdata[7] |=> !prescaler_held)
        else $error("prescaler clear bit stuck without hold mode");
    hold_load_a:
        assert property (gwr && wdata[7] |=> prescaler_held == $past(wdata[0]))
        else $error("prescaler clear bit not kept as written");
    tick_edge_a:
        assert property (ext_count_tick |-> sel[2:1] == 2'b11 &&
            $past(ext_count_pin, 2) == sel[0] &&
            $past(ext_count_pin, 3) != sel[0])
        else $error("count tick without matching pin edge");
    rsvd_zero_a:
        assert property (rd && addr == TPF_ADDR_GTC |=> rdata[6:1] == 6'h00)
        else $error("reserved control bits read nonzero");
endmodule // tpf_sva
